// ===== core/spr_top.sv
// Setpoint relay controller: four setpoint comparators, first-relay delay
// and band logic, relay and annunciator drive, AHB-Lite register slave.
// Assumes the reading input is a signed count synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module spr_top #(
  parameter int unsigned CYCLES_PER_TICK = spr_pkg::TICK_CYCLES,
  parameter int unsigned READING_W       = spr_pkg::READING_W
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Measurement and outputs
  input  wire logic [READING_W-1:0]  reading,
  output logic [3:0]                 relay_drive,
  output logic [3:0]                 annunciator,
  output logic                       irq
);

  localparam int unsigned DW = spr_pkg::DELAY_W;

  // Signed compare of two readings
  function automatic logic above(input logic [READING_W-1:0] a, input logic [READING_W-1:0] b);
    above = $signed(a) > $signed(b);
  endfunction

  // Clamp a written delay to its documented range
  function automatic logic [DW-1:0] clamp_delay(input logic [31:0] v);
    clamp_delay = (v > 32'(spr_pkg::DELAY_MAX)) ? spr_pkg::DELAY_MAX : v[DW-1:0];
  endfunction

  // Zero-extend a setpoint for the read mux
  function automatic logic [31:0] widen_sp(input logic [READING_W-1:0] v);
    widen_sp = {{(32-READING_W){1'b0}}, v};
  endfunction

  // Registers
  logic [READING_W-1:0] setpoint_one;
  logic [READING_W-1:0] setpoint_two;
  logic [READING_W-1:0] setpoint_three;
  logic [READING_W-1:0] setpoint_four;
  logic [DW-1:0]        make_delay;
  logic [DW-1:0]        break_delay;
  logic [3:0]           relay_direction_pattern;
  logic                 pump_band_select;
  logic [3:0]           irq_status;
  logic [3:0]           irq_mask;

  // Bus data phase
  logic                 dp_valid;
  logic                 dp_write;
  logic [7:0]           dp_addr;
  logic                 addr_take;

  // Zero wait states: every transfer answers in its data phase
  assign addr_take = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else begin
      dp_valid <= addr_take;
      dp_write <= addr_take && hwrite;
      dp_addr  <= addr_take ? {haddr[7:2], 2'b00} : dp_addr;
    end
  end

  // Write decode; writes land at the edge that ends the data phase
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = dp_write && (dp_addr == ofs);
  endfunction

  logic wr_sp1;
  logic wr_sp2;
  logic wr_sp3;
  logic wr_sp4;
  logic wr_make;
  logic wr_break;
  logic wr_ctl;
  logic wr_stat;
  logic wr_mask;

  assign wr_sp1   = wr_hit(spr_pkg::OFS_SETPOINT_ONE);
  assign wr_sp2   = wr_hit(spr_pkg::OFS_SETPOINT_TWO);
  assign wr_sp3   = wr_hit(spr_pkg::OFS_SETPOINT_THREE);
  assign wr_sp4   = wr_hit(spr_pkg::OFS_SETPOINT_FOUR);
  assign wr_make  = wr_hit(spr_pkg::OFS_MAKE_DELAY);
  assign wr_break = wr_hit(spr_pkg::OFS_BREAK_DELAY);
  assign wr_ctl   = wr_hit(spr_pkg::OFS_CONTROL);
  assign wr_stat  = wr_hit(spr_pkg::OFS_IRQ_STATUS);
  assign wr_mask  = wr_hit(spr_pkg::OFS_IRQ_MASK);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setpoint_one   <= spr_pkg::SETPOINT_RESET;
      setpoint_two   <= spr_pkg::SETPOINT_RESET;
      setpoint_three <= spr_pkg::SETPOINT_RESET;
      setpoint_four  <= spr_pkg::SETPOINT_RESET;
    end else begin
      setpoint_one   <= wr_sp1 ? hwdata[READING_W-1:0] : setpoint_one;
      setpoint_two   <= wr_sp2 ? hwdata[READING_W-1:0] : setpoint_two;
      setpoint_three <= wr_sp3 ? hwdata[READING_W-1:0] : setpoint_three;
      setpoint_four  <= wr_sp4 ? hwdata[READING_W-1:0] : setpoint_four;
    end
  end

  // Oversized delays clamp rather than wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      make_delay              <= spr_pkg::DELAY_RESET;
      break_delay             <= spr_pkg::DELAY_RESET;
      relay_direction_pattern <= spr_pkg::DIR_RESET;
      pump_band_select        <= spr_pkg::BAND_RESET;
      irq_mask                <= spr_pkg::MASK_RESET;
    end else begin
      make_delay              <= wr_make ? clamp_delay(hwdata) : make_delay;
      break_delay             <= wr_break ? clamp_delay(hwdata) : break_delay;
      relay_direction_pattern <= wr_ctl ? hwdata[spr_pkg::CTL_DIR_LSB +: 4] : relay_direction_pattern;
      pump_band_select        <= wr_ctl ? hwdata[spr_pkg::CTL_BAND_BIT] : pump_band_select;
      irq_mask                <= wr_mask ? hwdata[3:0] : irq_mask;
    end
  end

  // Seconds tick; free-running, so a delay may end up to one second early
  localparam int unsigned TW = $clog2(CYCLES_PER_TICK + 1);
  logic [TW-1:0] tick_count;
  logic          tick;

  assign tick = tick_count == TW'(CYCLES_PER_TICK - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_count <= '0;
    end else begin
      tick_count <= tick ? '0 : tick_count + TW'(1);
    end
  end

  // Comparators, one per setpoint; bit 3 is setpoint one
  logic [3:0] dir_high;
  logic [3:0] cmp;
  logic [3:0] set_above;
  logic [3:0] set_below;

  assign dir_high     = relay_direction_pattern;
  assign set_above[3] = above(reading, setpoint_one);
  assign set_above[2] = above(reading, setpoint_two);
  assign set_above[1] = above(reading, setpoint_three);
  assign set_above[0] = above(reading, setpoint_four);
  assign set_below[3] = above(setpoint_one, reading);
  assign set_below[2] = above(setpoint_two, reading);
  assign set_below[1] = above(setpoint_three, reading);
  assign set_below[0] = above(setpoint_four, reading);
  // Strict compares: a reading equal to a setpoint never trips it
  // Every setpoint is evaluated, fitted relay or not
  assign cmp = (dir_high & set_above) | (~dir_high & set_below);

  // Band mode for relay one
  logic band_active;
  logic band_latch;
  logic band_on;
  logic band_off;
  logic band_alarm;
  logic alarm_one;

  assign band_active = pump_band_select && above(setpoint_two, setpoint_one);
  // Low: fill below one until two; high: empty above two until one
  assign band_on  = dir_high[3] ? set_above[2] : set_below[3];
  assign band_off = dir_high[3] ? !set_above[3] : !set_below[2];
  assign band_alarm = band_on || (band_latch && !band_off);
  assign alarm_one  = band_active ? band_alarm : cmp[3];

  // Latch drops whenever band mode lapses, so no stale hysteresis
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      band_latch <= 1'b0;
    end else begin
      band_latch <= band_active && band_alarm;
    end
  end

  // Relay one with its make and break delays
  logic          relay_one;
  logic [DW-1:0] delay_elapsed;

  spr_delay_timer #(
    .DELAY_W     (DW)
  ) u_delay (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .tick        (tick),
    .alarm       (alarm_one),
    .make_delay  (make_delay),
    .break_delay (break_delay),
    .relay       (relay_one),
    .elapsed     (delay_elapsed)
  );

  // Annunciators mirror the drive so unfitted relays still indicate
  // Outputs; two, three and four follow their comparison
  logic [3:0] next_drive;
  assign next_drive = {relay_one, cmp[2:0]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      relay_drive <= 4'h0;
      annunciator <= 4'h0;
    end else begin
      relay_drive <= next_drive;
      annunciator <= next_drive;
    end
  end

  // Sticky change events; a new event beats a same-cycle clear
  logic [3:0] events;
  logic [3:0] stat_clear;
  logic [3:0] next_status;

  assign events      = next_drive ^ relay_drive;
  assign stat_clear  = wr_stat ? hwdata[3:0] : 4'h0;
  assign next_status = (irq_status & ~stat_clear) | events;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= 4'h0;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_status;
      irq        <= |(next_status & irq_mask);
    end
  end

  // Read mux over the data phase
  logic [31:0] state_word;
  logic [31:0] ctl_word;
  logic [31:0] rd_word;

  // Field positions live in the package so software and logic agree
  always_comb begin
    state_word                                 = 32'h0000_0000;
    state_word[spr_pkg::ST_OUT_LSB +: 4]       = relay_drive;
    state_word[spr_pkg::ST_CMP_LSB +: 4]       = cmp;
    state_word[spr_pkg::ST_BAND_BIT]           = band_active;
    state_word[spr_pkg::ST_ALARM_BIT]          = alarm_one;
    state_word[spr_pkg::ST_ELAPSED_LSB +: DW]  = delay_elapsed;
  end

  always_comb begin
    ctl_word                                = 32'h0000_0000;
    ctl_word[spr_pkg::CTL_DIR_LSB +: 4]     = relay_direction_pattern;
    ctl_word[spr_pkg::CTL_BAND_BIT]         = pump_band_select;
  end

  always_comb begin
    unique case (dp_addr)
      spr_pkg::OFS_SETPOINT_ONE:   rd_word = widen_sp(setpoint_one);
      spr_pkg::OFS_SETPOINT_TWO:   rd_word = widen_sp(setpoint_two);
      spr_pkg::OFS_SETPOINT_THREE: rd_word = widen_sp(setpoint_three);
      spr_pkg::OFS_SETPOINT_FOUR:  rd_word = widen_sp(setpoint_four);
      spr_pkg::OFS_MAKE_DELAY:     rd_word = {{(32-DW){1'b0}}, make_delay};
      spr_pkg::OFS_BREAK_DELAY:    rd_word = {{(32-DW){1'b0}}, break_delay};
      spr_pkg::OFS_CONTROL:        rd_word = ctl_word;
      spr_pkg::OFS_STATE:          rd_word = state_word;
      spr_pkg::OFS_IRQ_STATUS:     rd_word = {28'h0, irq_status};
      spr_pkg::OFS_IRQ_MASK:       rd_word = {28'h0, irq_mask};
      default:                     rd_word = 32'h0000_0000;
    endcase
  end

  // Read data only during a read data phase
  assign hrdata = (dp_valid && !dp_write) ? rd_word : 32'h0000_0000;

endmodule
`default_nettype wire

// ===== core/spr_pkg.sv
// Package for the setpoint relay controller: register map, field layout,
// reset values and timing constants.
// Assumes one 50 MHz clock and a 32-bit AHB-Lite register bus.
package spr_pkg;

  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned READING_W      = 16;
  localparam int unsigned DELAY_W        = 14;

  // Register byte offsets
  localparam logic [7:0]  OFS_SETPOINT_ONE   = 8'h00;
  localparam logic [7:0]  OFS_SETPOINT_TWO   = 8'h04;
  localparam logic [7:0]  OFS_SETPOINT_THREE = 8'h08;
  localparam logic [7:0]  OFS_SETPOINT_FOUR  = 8'h0C;
  localparam logic [7:0]  OFS_MAKE_DELAY     = 8'h10;
  localparam logic [7:0]  OFS_BREAK_DELAY    = 8'h14;
  localparam logic [7:0]  OFS_CONTROL        = 8'h18;
  localparam logic [7:0]  OFS_STATE          = 8'h1C;
  localparam logic [7:0]  OFS_IRQ_STATUS     = 8'h20;
  localparam logic [7:0]  OFS_IRQ_MASK       = 8'h24;

  // Control fields: [3:0] direction pattern (bit 3 = setpoint one), [4] band
  localparam int unsigned CTL_DIR_LSB    = 0;
  localparam int unsigned CTL_BAND_BIT   = 4;

  // State fields
  localparam int unsigned ST_OUT_LSB     = 0;
  localparam int unsigned ST_CMP_LSB     = 4;
  localparam int unsigned ST_BAND_BIT    = 8;
  localparam int unsigned ST_ALARM_BIT   = 9;
  localparam int unsigned ST_ELAPSED_LSB = 10;

  // Reset values
  localparam logic [15:0] SETPOINT_RESET = 16'h270F;  // 9999, out of reach
  localparam logic [13:0] DELAY_RESET    = 14'h0000;
  localparam logic [13:0] DELAY_MAX      = 14'h270F;  // 9999 seconds
  localparam logic [3:0]  DIR_RESET      = 4'hF;      // All high
  localparam logic        BAND_RESET     = 1'b0;
  localparam logic [3:0]  MASK_RESET     = 4'h0;

  // Seconds tick
  localparam longint unsigned SECOND_NS     = 1000000000;
  localparam longint unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned     TICK_CYCLES   = int'(SECOND_NS / CLK_PERIOD_NS);

endpackage

// ===== core/spr_delay_timer.sv
// Delay-on-make / delay-on-break filter for the first setpoint relay.
// Assumes a one-cycle seconds tick from the parent, same clock.
`timescale 1ns/1ps
`default_nettype none
module spr_delay_timer #(
  parameter int unsigned DELAY_W = spr_pkg::DELAY_W
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               tick,
  input  wire logic               alarm,
  input  wire logic [DELAY_W-1:0] make_delay,
  input  wire logic [DELAY_W-1:0] break_delay,
  output logic                    relay,
  output logic [DELAY_W-1:0]      elapsed
);

  logic               pending;
  logic [DELAY_W-1:0] target;
  logic [DELAY_W-1:0] next_elapsed;
  logic               expire;

  assign pending      = alarm != relay;
  assign target       = alarm ? make_delay : break_delay;
  assign next_elapsed = elapsed + DELAY_W'(1);
  // Zero delay switches at once; otherwise on the tick that completes it
  assign expire       = pending && ((target == '0) || (tick && next_elapsed >= target));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      relay   <= 1'b0;
      elapsed <= '0;
    end else if (!pending || expire) begin
      // An interrupted condition restarts the count
      relay   <= expire ? alarm : relay;
      elapsed <= '0;
    end else if (tick) begin
      elapsed <= next_elapsed;
    end
  end

endmodule
`default_nettype wire

// ===== dv/spr_asserts.sv
// Checker for spr_top: bus answer, outputs and interrupt timing.
// Assumes hready is tied to hreadyout.
`timescale 1ns/1ps
`default_nettype none
module spr_asserts #(
  parameter int unsigned READING_W = 16
) (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [31:0]          hwdata,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic [31:0]          hrdata,
  input wire logic [READING_W-1:0] reading,
  input wire logic [3:0]           relay_drive,
  input wire logic [3:0]           annunciator,
  input wire logic                 irq
);
  logic                 wr_dp;
  logic                 rd_dp;
  logic [7:0]           a_q;
  logic [READING_W-1:0] r_q;
  logic [3:0]           rl_q;
  wire                  take  = hsel && htrans[1] && hready;
  wire                  ev    = relay_drive != rl_q;
  wire                  cause = (reading != r_q) || wr_dp;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp <= 1'b0;
      rd_dp <= 1'b0;
      a_q   <= 8'h00;
      r_q   <= '0;
      rl_q  <= 4'h0;
    end else begin
      wr_dp <= take && hwrite;
      rd_dp <= take && !hwrite;
      a_q   <= haddr[7:0];
      r_q   <= reading;
      rl_q  <= relay_drive;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Mask goes in at the data phase edge, irq is one register later
  sequence mask_off_s;
    wr_dp && a_q == spr_pkg::OFS_IRQ_MASK && hwdata[3:0] == 4'h0;
  endsequence
  sequence irq_cause_s;
    $past(ev) || $past(wr_dp) || $past(ev, 2) || $past(wr_dp, 2);
  endsequence
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or error response");
  annun_match_a: assert property (annunciator == relay_drive)
    else $error("annunciator differs from relay drive");
  rdata_idle_a: assert property (!rd_dp |-> hrdata == 32'h0)
    else $error("read data outside read data phase");
  rdata_upper_a: assert property (hrdata[31:24] == 8'h00)
    else $error("unused read data bits set");
  fast_bits_a: assert property ($changed(relay_drive[2:0]) |-> cause || $past(cause) || $past(cause, 2))
    else $error("undelayed relay moved without cause");
  irq_rise_a: assert property ($rose(irq) |-> irq_cause_s)
    else $error("irq rose without relay change or write");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr_dp) || $past(wr_dp, 2))
    else $error("irq fell without a write");
  mask_off_a: assert property (mask_off_s |-> ##2 !irq)
    else $error("irq high after mask cleared");
endmodule
bind spr_top spr_asserts #(.READING_W(READING_W)) u_asserts (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .reading(reading), .relay_drive(relay_drive),
  .annunciator(annunciator), .irq(irq)
);
`default_nettype wire

// ===== dv/spr_coil_model.sv
// Relay coil and annunciator lamp load seen by spr_top.
// Assumes high-active drives on the same clock.
`timescale 1ns/1ps
`default_nettype none
module spr_coil_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [3:0] drive,
  input  wire logic [3:0] lamp,
  output logic [3:0]      coil,
  output logic [3:0]      lit
);
  // Coils drop out while the controller is in reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coil <= 4'h0;
      lit  <= 4'h0;
    end else begin
      coil <= drive;
      lit  <= lamp;
    end
  end
endmodule
`default_nettype wire

// ===== dv/setpoint_relay_controller_tb.sv
// Self-checking bench for spr_top with the coil load model.
// Assumes 50 MHz hclk and a ten-cycle seconds tick.
`timescale 1ns/1ps
`default_nettype none
module setpoint_relay_controller_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] reading = 16'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [3:0]  relay_drive;
  logic [3:0]  annunciator;
  logic        irq;
  logic [3:0]  coil;
  logic [3:0]  lit;
  wire         hready = hreadyout;
  int          error_cnt = 0;
  int          n_tests = 0;
  spr_top #(.CYCLES_PER_TICK(10)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .reading(reading), .relay_drive(relay_drive),
    .annunciator(annunciator), .irq(irq)
  );
  spr_coil_model u_coil (
    .hclk(hclk), .hresetn(hresetn), .drive(relay_drive), .lamp(annunciator), .coil(coil), .lit(lit)
  );
  initial begin
    forever #10 hclk = ~hclk;
  end
  task automatic stop_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic rdg(input logic [15:0] v);
    @(posedge hclk);
    reading <= v;
  endtask
  // Coil model lags one cycle, so three cycles cover every stage
  task automatic step(input logic [15:0] v, input logic [3:0] m, input logic [3:0] e);
    rdg(v);
    cyc(3);
    chk({28'h0, relay_drive & m}, {28'h0, e});
    chk({28'h0, coil & lit & m}, {28'h0, e});
  endtask
  task automatic t_reset();
    rdc(spr_pkg::OFS_SETPOINT_ONE, 32'h0000270F);
    rdc(spr_pkg::OFS_CONTROL, 32'h0000000F);
    rdc(spr_pkg::OFS_MAKE_DELAY, 32'h0);
    rdc(8'h3C, 32'h0);
    chk({28'h0, relay_drive}, 32'h0);
  endtask
  task automatic t_direct();
    for (int i = 0; i < 4; i++) wr(spr_pkg::OFS_SETPOINT_ONE + 8'(4 * i), 32'h64);
    wr(spr_pkg::OFS_CONTROL, 32'h05);
    step(16'h0032, 4'hF, 4'hA);
    step(16'h0096, 4'hF, 4'h5);
    step(16'h0064, 4'hF, 4'h0);
    step(16'hFFCE, 4'hF, 4'hA);
  endtask
  task automatic t_band();
    wr(spr_pkg::OFS_SETPOINT_TWO, 32'hC8);
    wr(spr_pkg::OFS_CONTROL, 32'h17);
    step(16'h0032, 4'h8, 4'h8);
    step(16'h0096, 4'h8, 4'h8);
    step(16'h00C8, 4'h8, 4'h0);
    step(16'h0096, 4'h8, 4'h0);
    wr(spr_pkg::OFS_CONTROL, 32'h1F);
    step(16'h00FA, 4'h8, 4'h8);
    step(16'h0096, 4'h8, 4'h8);
    step(16'h0064, 4'h8, 4'h0);
    step(16'h0096, 4'h8, 4'h0);
    wr(spr_pkg::OFS_SETPOINT_TWO, 32'h32);
    step(16'h0096, 4'h8, 4'h8);
  endtask
  task automatic t_delay();
    wr(spr_pkg::OFS_SETPOINT_TWO, 32'h270F);
    wr(spr_pkg::OFS_CONTROL, 32'h0F);
    step(16'h0032, 4'hF, 4'h0);
    wr(spr_pkg::OFS_MAKE_DELAY, 32'h3FFF);
    rdc(spr_pkg::OFS_MAKE_DELAY, 32'h270F);
    wr(spr_pkg::OFS_MAKE_DELAY, 32'h3);
    wr(spr_pkg::OFS_BREAK_DELAY, 32'h3);
    rdg(16'h0096);
    cyc(15);
    chk({28'h0, relay_drive}, 32'h3);
    rdg(16'h0032);
    cyc(3);
    rdg(16'h0096);
    cyc(12);
    chk({31'h0, relay_drive[3]}, 32'h0);
    cyc(28);
    chk({31'h0, relay_drive[3]}, 32'h1);
    rdg(16'h0032);
    cyc(15);
    chk({31'h0, relay_drive[3]}, 32'h1);
    cyc(25);
    chk({31'h0, relay_drive[3]}, 32'h0);
  endtask
  task automatic t_irq();
    for (int i = 0; i < 4; i++) wr(spr_pkg::OFS_SETPOINT_ONE + 8'(4 * i), 32'h270F);
    wr(spr_pkg::OFS_IRQ_MASK, 32'h0);
    wr(spr_pkg::OFS_IRQ_STATUS, 32'hF);
    wr(spr_pkg::OFS_SETPOINT_FOUR, 32'hF831);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    rdc(spr_pkg::OFS_IRQ_STATUS, 32'h1);
    wr(spr_pkg::OFS_IRQ_MASK, 32'h1);
    cyc(3);
    chk({31'h0, irq}, 32'h1);
    wr(spr_pkg::OFS_IRQ_STATUS, 32'h1);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    rdc(spr_pkg::OFS_IRQ_STATUS, 32'h0);
    rdc(spr_pkg::OFS_STATE, 32'h00000011);
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_direct();
    t_band();
    t_delay();
    t_irq();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
